// ===== hdl/rtc_pkg.sv
// Shared constants for the prescale, vector and converter register block.
package rtc_pkg;
  // Register bus widths.
  localparam int ADDR_W = 4;
  localparam int DATA_W = 16;
  // Register offsets on the plain register port.
  localparam logic [3:0] ADDR_CTL_A   = 4'h0;
  localparam logic [3:0] ADDR_CTL_B   = 4'h1;
  localparam logic [3:0] ADDR_CNT_A   = 4'h2;
  localparam logic [3:0] ADDR_CNT_B   = 4'h3;
  localparam logic [3:0] ADDR_VECTOR  = 4'h4;
  localparam logic [3:0] ADDR_TO_DEC  = 4'h5;
  localparam logic [3:0] ADDR_TO_BIN  = 4'h6;
  localparam logic [3:0] ADDR_SEC_BK  = 4'h7;
  localparam logic [3:0] ADDR_MIN_BK  = 4'h8;
  // Control register field positions.
  localparam int SRC_MSB  = 15;
  localparam int SRC_LSB  = 14;
  localparam int DIV_MSB  = 13;
  localparam int DIV_LSB  = 11;
  localparam int HOLD_BIT = 8;
  localparam int IP_MSB   = 4;
  localparam int IP_LSB   = 2;
  localparam int IE_BIT   = 1;
  localparam int FLAG_BIT = 0;
  // Writable bits of each control register; all others read zero.
  localparam logic [15:0] CTL_A_MASK  = 16'h391F;
  localparam logic [15:0] CTL_B_MASK  = 16'hF91F;
  localparam logic [15:0] CTL_RESET   = 16'h0100;
  // Fixed divide codes used in calendar mode (/256 and /128).
  localparam logic [2:0]  CAL_DIV_A   = 3'h7;
  localparam logic [2:0]  CAL_DIV_B   = 3'h6;
  // Source code bit that picks the first stage output.
  localparam int SRC_FROM_A = 1;
  // Backup register masks.
  localparam logic [7:0]  SEC_MASK    = 8'h7F;
  localparam logic [7:0]  MIN_MASK    = 8'h3F;
  // Vector sources, highest priority first.
  localparam int SRC_OSC   = 0;
  localparam int SRC_TAMP  = 1;
  localparam int SRC_RDY   = 2;
  localparam int SRC_INTV  = 3;
  localparam int SRC_ALARM = 4;
  localparam int SRC_PA    = 5;
  localparam int SRC_PB    = 6;
  localparam int NUM_SRC   = 7;
  localparam int NUM_EXT   = 5;
  localparam logic [15:0] VEC_NONE = 16'h0000;
  localparam logic [15:0] VEC_STEP = 16'h0002;
  // Converter widths.
  localparam int BIN_W = 12;
  localparam int DEC_W = 16;
  localparam int DIGIT_W = 4;
endpackage

// ===== hdl/conv_if.sv
// Carrier between the register core and the number converter.
`timescale 1ns/1ps
`default_nettype none
interface conv_if;
  logic        wr_bin;            // Write of a binary number.
  logic        wr_dec;            // Write of a packed decimal number.
  logic [15:0] wdata;             // Value being written.
  logic [15:0] bin_to_dec_value;  // Packed decimal result.
  logic [15:0] dec_to_bin_value;  // Binary result, low bits only.
  modport core (output wr_bin, output wr_dec, output wdata,
                input bin_to_dec_value, input dec_to_bin_value);
  modport conv (input wr_bin, input wr_dec, input wdata,
                output bin_to_dec_value, output dec_to_bin_value);
endinterface
`default_nettype wire

// ===== hdl/rtc_convert.sv
// Binary and packed decimal converter pair.
`timescale 1ns/1ps
`default_nettype none
module rtc_convert (
  // Clock and reset.
  input  wire logic mclk,
  input  wire logic rst,
  // Link to the register core.
  conv_if.conv      cv
);
  import rtc_pkg::*;

  // Shift-and-add-three conversion of a 12-bit binary value.
  function automatic logic [15:0] to_dec(input logic [11:0] b);
    logic [27:0] s;
    s = {16'h0000, b};
    for (int i = 0; i < BIN_W; i++) begin
      for (int d = 0; d < DEC_W / DIGIT_W; d++) begin
        if (s[BIN_W + DIGIT_W * d +: DIGIT_W] >= 4'h5) begin
          s[BIN_W + DIGIT_W * d +: DIGIT_W] =
            s[BIN_W + DIGIT_W * d +: DIGIT_W] + 4'h3;
        end
      end
      s = s << 1;
    end
    return s[27:12];
  endfunction

  // Weighted digit sum; values above 4095 lose their top bits.
  function automatic logic [11:0] to_bin(input logic [15:0] v);
    logic [15:0] sum;
    sum = 16'(v[15:12]) * 16'd1000 + 16'(v[11:8]) * 16'h0064
        + 16'(v[7:4]) * 16'h000A + 16'(v[3:0]);
    return sum[11:0];
  endfunction

  logic [15:0] dec_ff;  // Last decimal result.
  logic [11:0] bin_ff;  // Last binary result.

  // The result is ready on the edge of the write, so a read may follow.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      dec_ff <= 16'h0000;
      bin_ff <= 12'h000;
    end else begin
      if (cv.wr_bin) dec_ff <= to_dec(cv.wdata[11:0]);
      if (cv.wr_dec) bin_ff <= to_bin(cv.wdata);
    end
  end

  assign cv.bin_to_dec_value = dec_ff;
  assign cv.dec_to_bin_value = {4'h0, bin_ff};

  to_dec_a: assert property (@(posedge mclk) disable iff (rst)
    cv.wr_bin && cv.wdata[11:0] == 12'h0FF |=> dec_ff == 16'h0255)
    else $error("Binary 255 did not convert to decimal 255.");
  to_bin_a: assert property (@(posedge mclk) disable iff (rst)
    cv.wr_dec && cv.wdata == 16'h4095 |=> bin_ff == 12'hFFF)
    else $error("Decimal 4095 did not convert to binary.");
endmodule // rtc_convert
`default_nettype wire

// ===== hdl/rtc_prescale.sv
// Prescale timers, interrupt vector, converters and backup registers.
//
// Local design decisions: the address map and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - First stage divides by two to 256
// - Calendar mode fixes /256 and /128 outputs
// - First hold resets set, ignored in calendar
// - Second hold resets set, ignored in calendar
// - Second source: crystal or first stage output
// - Calendar mode sources second from first
// - First interval field picks flag tap
// - Second interval field picks flag tap
// - Flag sets on interval; enable gates request
// - Enabled second flag wakes deep sleep
// - Configuration held until lock release
// - Counters readable and writable by software
// - Vector codes without tamper detection
// - Vector codes with tamper detection
// - Binary write reads back as decimal
// - Decimal write reads back as binary
// - Backups cleared only by supply reset
// - Seconds backup holds binary or decimal
// - Minutes backup upper bits read zero
// - Reserved control bits read zero
module rtc_prescale #(
  parameter bit TAMPER_PRESENT = 1'b0  // Tamper source in the vector.
) (
  // Clock and resets.
  input  wire logic                  mclk,
  input  wire logic                  rst,
  input  wire logic                  supply_rst,
  // Register port.
  input  wire logic [rtc_pkg::ADDR_W-1:0] addr,
  input  wire logic [rtc_pkg::DATA_W-1:0] wdata,
  input  wire logic                  wr,
  input  wire logic                  rd,
  output logic [rtc_pkg::DATA_W-1:0] rdata,
  // Crystal clock pin, sampled.
  input  wire logic                  xtal_clk,
  // Mode and power controls from the calendar and power blocks.
  input  wire logic                  calendar_mode,
  input  wire logic                  module_hold,
  input  wire logic                  low_power_io_lock,
  input  wire logic                  deep_sleep_mode,
  // Pending enabled flags of other sources and their clear pulses.
  input  wire logic [rtc_pkg::NUM_EXT-1:0] ext_pending,
  output logic [rtc_pkg::NUM_EXT-1:0] ext_clear,
  // Results.
  output logic                       irq_request,
  output logic                       wake_event,
  output logic                       second_tick
);
  import rtc_pkg::*;

  // Decode a tap code: true when the low code+1 bits are all ones.
  function automatic logic tap_carry(input logic [7:0] cnt,
                                     input logic [2:0] sel);
    logic [7:0] mask;
    mask = 8'((9'h002 << sel) - 9'h001);
    return &(cnt | ~mask);
  endfunction

  // Vector code for a source index under the selected variant.
  function automatic logic [15:0] vec_code(input int idx);
    logic [15:0] n;
    n = 16'(idx);
    if (TAMPER_PRESENT || idx == SRC_OSC) return VEC_STEP * (n + 16'h0001);
    return VEC_STEP * n;
  endfunction

  // Register state.
  logic [15:0] ctl_a_ff, ctl_b_ff;     // Software view of control.
  logic [15:0] eff_a_ff, eff_b_ff;     // Configuration in effect.
  logic [7:0]  cnt_a_ff, cnt_b_ff;     // Stage counters.
  logic [7:0]  sec_bk_ff, min_bk_ff;   // Backup timestamps.
  logic [2:0]  xs_ff;                  // Crystal pin synchroniser.
  logic        xlvl_ff;                // Accepted crystal level.
  logic [15:0] rdata_ff;
  logic [NUM_EXT-1:0] ext_clear_ff;
  logic        irq_ff, wake_ff, sec_ff;
  logic        flag_a_ff, flag_b_ff;

  // Decoded strobes.
  wire wr_ctl_a = wr && addr == ADDR_CTL_A;
  wire wr_ctl_b = wr && addr == ADDR_CTL_B;
  wire wr_cnt_a = wr && addr == ADDR_CNT_A;
  wire wr_cnt_b = wr && addr == ADDR_CNT_B;
  wire rd_vec   = rd && addr == ADDR_VECTOR;

  // Crystal rising edge once the second and third stages agree.
  wire xtal_agree = xs_ff[1] == xs_ff[2];
  wire xtal_rise  = xtal_agree && xs_ff[2] && !xlvl_ff;

  // Effective fields; calendar mode overrides divide, hold and source.
  wire [2:0] div_a  = calendar_mode ? CAL_DIV_A
                                    : eff_a_ff[DIV_MSB:DIV_LSB];
  wire [2:0] div_b  = calendar_mode ? CAL_DIV_B
                                    : eff_b_ff[DIV_MSB:DIV_LSB];
  wire hold_a = calendar_mode ? module_hold
                              : eff_a_ff[HOLD_BIT];
  wire hold_b = calendar_mode ? module_hold
                              : eff_b_ff[HOLD_BIT];
  wire b_from_a = calendar_mode
                  || eff_b_ff[SRC_LSB + SRC_FROM_A];
  wire [2:0] ip_a = eff_a_ff[IP_MSB:IP_LSB];
  wire [2:0] ip_b = eff_b_ff[IP_MSB:IP_LSB];

  // Stage steps; a software write to the counter takes precedence.
  wire step_a  = xtal_rise && !hold_a;
  wire out_a   = step_a && tap_carry(cnt_a_ff, div_a);
  wire clk_b   = b_from_a ? out_a : xtal_rise;
  wire step_b  = clk_b && !hold_b;
  wire out_b   = step_b && tap_carry(cnt_b_ff, div_b);
  wire ev_a    = step_a && tap_carry(cnt_a_ff, ip_a);
  wire ev_b    = step_b && tap_carry(cnt_b_ff, ip_b);

  // Pending enabled sources, highest priority at index zero.
  wire [NUM_SRC-1:0] pend = {
    flag_b_ff && eff_b_ff[IE_BIT], flag_a_ff && eff_a_ff[IE_BIT],
    ext_pending[SRC_ALARM], ext_pending[SRC_INTV], ext_pending[SRC_RDY],
    ext_pending[SRC_TAMP] && TAMPER_PRESENT, ext_pending[SRC_OSC]};

  // Priority pick, done as a loop from lowest to highest priority.
  logic [15:0] vec_now;
  logic [NUM_SRC-1:0] vec_hit;
  always_comb begin
    vec_now = VEC_NONE;
    vec_hit = '0;
    for (int i = NUM_SRC - 1; i >= 0; i--) begin
      if (pend[i]) begin
        vec_now = vec_code(i);
        vec_hit = NUM_SRC'(1) << i;
      end
    end
  end
  wire [NUM_SRC-1:0] vec_clr = rd_vec ? vec_hit : '0;

  // Converter link.
  conv_if cv ();
  assign cv.wr_bin = wr && addr == ADDR_TO_DEC;
  assign cv.wr_dec = wr && addr == ADDR_TO_BIN;
  assign cv.wdata  = wdata;
  rtc_convert u_conv (
    .mclk (mclk),
    .rst  (rst),
    .cv   (cv)
  );

  // Read multiplexer; unmapped offsets return zero.
  logic [15:0] rd_mux;
  always_comb begin
    unique case (addr)
      ADDR_CTL_A:  rd_mux = {ctl_a_ff[15:1], flag_a_ff} & CTL_A_MASK;
      ADDR_CTL_B:  rd_mux = {ctl_b_ff[15:1], flag_b_ff} & CTL_B_MASK;
      ADDR_CNT_A:  rd_mux = {8'h00, cnt_a_ff};
      ADDR_CNT_B:  rd_mux = {8'h00, cnt_b_ff};
      ADDR_VECTOR: rd_mux = vec_now;
      ADDR_TO_DEC: rd_mux = cv.bin_to_dec_value;
      ADDR_TO_BIN: rd_mux = cv.dec_to_bin_value;
      ADDR_SEC_BK: rd_mux = {8'h00, sec_bk_ff & SEC_MASK};
      ADDR_MIN_BK: rd_mux = {8'h00, min_bk_ff & MIN_MASK};
      default:     rd_mux = 16'h0000;
    endcase
  end

  // Crystal pin synchroniser; only the second stage reads the first.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      xs_ff   <= 3'h0;
      xlvl_ff <= 1'b0;
    end else begin
      xs_ff <= {xs_ff[1:0], xtal_clk};
      if (xtal_agree) xlvl_ff <= xs_ff[2];
    end
  end

  // Control registers. Deep sleep loses the bits but the effective copy
  // is frozen while the lock stands, so timing carries on unchanged.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ctl_a_ff <= CTL_RESET;
      ctl_b_ff <= CTL_RESET;
    end else if (deep_sleep_mode) begin
      ctl_a_ff <= CTL_RESET;
      ctl_b_ff <= CTL_RESET;
    end else begin
      if (wr_ctl_a) ctl_a_ff <= wdata & CTL_A_MASK;
      if (wr_ctl_b) ctl_b_ff <= wdata & CTL_B_MASK;
    end
  end

  // Effective configuration follows software only while unlocked.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      eff_a_ff <= CTL_RESET;
      eff_b_ff <= CTL_RESET;
    end else if (!low_power_io_lock) begin
      eff_a_ff <= ctl_a_ff;
      eff_b_ff <= ctl_b_ff;
    end
  end

  // Event flags: the hardware set wins over any clear in the same cycle.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      flag_a_ff <= 1'b0;
      flag_b_ff <= 1'b0;
    end else begin
      if (ev_a) flag_a_ff <= 1'b1;
      else if (vec_clr[SRC_PA]) flag_a_ff <= 1'b0;
      else if (wr_ctl_a) flag_a_ff <= wdata[FLAG_BIT];
      else if (deep_sleep_mode) flag_a_ff <= 1'b0;
      if (ev_b) flag_b_ff <= 1'b1;
      else if (vec_clr[SRC_PB]) flag_b_ff <= 1'b0;
      else if (wr_ctl_b) flag_b_ff <= wdata[FLAG_BIT];
      else if (deep_sleep_mode) flag_b_ff <= 1'b0;
    end
  end

  // Stage counters. The main reset clears them to zero; a software write loads them.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cnt_a_ff <= 8'h00;
      cnt_b_ff <= 8'h00;
    end else begin
      if (wr_cnt_a) cnt_a_ff <= wdata[7:0];
      else if (step_a) cnt_a_ff <= cnt_a_ff + 8'h01;
      if (wr_cnt_b) cnt_b_ff <= wdata[7:0];
      else if (step_b) cnt_b_ff <= cnt_b_ff + 8'h01;
    end
  end

  // Backup registers live on the supply reset, not on the main one.
  always_ff @(posedge mclk or posedge supply_rst) begin
    if (supply_rst) begin
      sec_bk_ff <= 8'h00;
      min_bk_ff <= 8'h00;
    end else begin
      if (wr && addr == ADDR_SEC_BK) sec_bk_ff <= wdata[7:0] & SEC_MASK;
      if (wr && addr == ADDR_MIN_BK) min_bk_ff <= wdata[7:0] & MIN_MASK;
    end
  end

  // Outputs: read data for one cycle, clear pulses and status levels.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rdata_ff     <= 16'h0000;
      ext_clear_ff <= '0;
      irq_ff       <= 1'b0;
      wake_ff      <= 1'b0;
      sec_ff       <= 1'b0;
    end else begin
      rdata_ff     <= rd ? rd_mux : 16'h0000;
      ext_clear_ff <= vec_clr[NUM_EXT-1:0];
      irq_ff       <= (flag_a_ff && eff_a_ff[IE_BIT])
                      || (flag_b_ff && eff_b_ff[IE_BIT]);
      wake_ff      <= flag_b_ff && eff_b_ff[IE_BIT];
      sec_ff       <= out_b;
    end
  end

  assign rdata       = rdata_ff;
  assign ext_clear   = ext_clear_ff;
  assign irq_request = irq_ff;
  assign wake_event  = wake_ff;
  assign second_tick = sec_ff;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst || supply_rst);

  hold_a_a: assert property (!calendar_mode && eff_a_ff[HOLD_BIT]
    && !wr_cnt_a |=> $stable(cnt_a_ff))
    else $error("First counter moved while held.");
  hold_b_a: assert property (calendar_mode && module_hold
    && !wr_cnt_b |=> $stable(cnt_b_ff))
    else $error("Second counter moved under module hold.");
  cal_src_a: assert property (calendar_mode && step_b |-> out_a)
    else $error("Second stage stepped without first stage output.");
  cal_div_a: assert property (calendar_mode && out_a
    |-> cnt_a_ff == 8'hFF)
    else $error("First stage output not at divide by 256.");
  flag_set_a: assert property (ev_a |=> flag_a_ff)
    else $error("First flag not set by its interval.");
  wake_a: assert property (flag_b_ff && eff_b_ff[IE_BIT]
    |=> wake_event)
    else $error("Wake event missing for enabled second flag.");
  lock_a: assert property (low_power_io_lock
    |=> $stable(eff_b_ff))
    else $error("Configuration changed while locked.");
  vec_clr_a: assert property (rd_vec && vec_hit[SRC_PA] && !ev_a
    |=> !flag_a_ff ##0 rdata[3:0] != 4'h0)
    else $error("Vector read did not clear the first flag.");
  vec_none_a: assert property (rd && addr == ADDR_VECTOR
    && pend == '0 |=> rdata == VEC_NONE)
    else $error("Empty vector not read as zero.");
  min_top_a: assert property (rd && addr == ADDR_MIN_BK
    |=> rdata[7:6] == 2'b00)
    else $error("Minutes backup upper bits not zero.");
  resv_a: assert property (rd && addr == ADDR_CTL_A
    |=> (rdata & ~CTL_A_MASK) == 16'h0000)
    else $error("Reserved control bits read nonzero.");
endmodule // rtc_prescale
`default_nettype wire

// ===== test/tb_rtc_prescale_vector_convert.sv
// Self-checking bench for the prescale, vector and converter block.
`timescale 1ns/1ps
`default_nettype none
module tb_rtc_prescale_vector_convert;
  import rtc_pkg::*;
  // Clock, resets and register port.
  logic        mclk       = 1'b0;
  logic        rst        = 1'b1;
  logic        supply_rst = 1'b1;
  logic [3:0]  addr       = 4'h0;
  logic [15:0] wdata      = 16'h0000;
  logic        wr         = 1'b0;
  logic        rd         = 1'b0;
  logic [15:0] rdata;
  // Crystal, mode pins and the outside sources.
  logic        xtal_clk   = 1'b0;
  logic        cal        = 1'b0;
  logic        mhold      = 1'b0;
  logic        lock       = 1'b0;
  logic        sleep      = 1'b0;
  logic [4:0]  ext_set    = 5'h00;
  logic [4:0]  ext_pend   = 5'h00;
  logic [4:0]  ext_clear;
  logic        irq;
  logic        wake;
  logic        tick;
  // Bench bookkeeping.
  int          errors       = 0;
  int          total_checks = 0;
  int          ticks        = 0;
  int          n;
  logic [15:0] v;
  logic [15:0] w;
  logic [15:0] r;

  rtc_prescale #(.TAMPER_PRESENT(1'b0)) dut (
    .mclk(mclk), .rst(rst), .supply_rst(supply_rst), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .xtal_clk(xtal_clk),
    .calendar_mode(cal), .module_hold(mhold), .low_power_io_lock(lock),
    .deep_sleep_mode(sleep), .ext_pending(ext_pend),
    .ext_clear(ext_clear), .irq_request(irq), .wake_event(wake),
    .second_tick(tick));

  // Free-running 100 MHz clock.
  always #5 mclk = ~mclk;

  // Outside flags stay up until their clear pulse; ticks are counted.
  always @(posedge mclk) begin
    ext_pend <= (ext_pend | ext_set) & ~ext_clear;
    if (tick === 1'b1) begin
      ticks <= ticks + 1;
    end
  end

  // Compares one value and reports a difference at once.
  task automatic check(input string name, input logic [15:0] exp,
                       input logic [15:0] got);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask

  // Single-cycle write strobe.
  task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
    @(posedge mclk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge mclk);
    wr    <= 1'b0;
  endtask

  // Read data stands only in the cycle after the strobe.
  task automatic rd_reg(input logic [3:0] a, output logic [15:0] d);
    @(posedge mclk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge mclk);
    rd   <= 1'b0;
    #1 d = rdata;
  endtask

  // Crystal rises, slow enough for the three-flop synchroniser.
  task automatic xstep(input int k);
    repeat (k) begin
      @(posedge mclk);
      xtal_clk <= 1'b1;
      repeat (4) @(posedge mclk);
      xtal_clk <= 1'b0;
      repeat (4) @(posedge mclk);
    end
  endtask

  // Counts crystal rises until the flag of a control register shows.
  task automatic rises_to_flag(input logic [3:0] a, output int cnt);
    logic [15:0] q;
    cnt = 0;
    q = 16'h0000;
    while (q[0] !== 1'b1 && cnt < 600) begin
      xstep(1);
      cnt++;
      rd_reg(a, q);
    end
  endtask

  // The first flag only aligns the phase; the second gives the period.
  task automatic flag_period(input logic [3:0] a, input logic [15:0] c,
                             output int cnt);
    wr_reg(a, c);
    rises_to_flag(a, cnt);
    wr_reg(a, c);
    rises_to_flag(a, cnt);
  endtask

  // Rises between two stage outputs, after one tick to align.
  task automatic tick_period(output int cnt);
    int t0;
    for (int j = 0; j < 2; j++) begin
      t0 = ticks;
      cnt = 0;
      while (ticks == t0 && cnt < 1100) begin
        xstep(1);
        cnt++;
      end
    end
  endtask

  // Decimal image of a binary number.
  function automatic logic [15:0] to_dec(input logic [11:0] b);
    int x;
    x = int'(b);
    return {4'(x / 1000), 4'(x / 100 % 10), 4'(x / 10 % 10), 4'(x % 10)};
  endfunction

  // Binary image of a packed decimal number.
  function automatic logic [15:0] to_bin(input logic [15:0] d);
    int x;
    x = d[15:12] * 1000 + d[11:8] * 100 + d[7:4] * 10 + d[3:0];
    return {4'h0, 12'(x)};
  endfunction

  // Ends the run with the verdict.
  task automatic print_verdict();
    if (errors == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // A hang counts as a failure.
  initial begin
    repeat (90000) @(posedge mclk);
    errors++;
    print_verdict();
  end

  // Main sequence.
  initial begin
    void'($urandom(67));
    repeat (12) @(posedge mclk);
    rst <= 1'b0;
    supply_rst <= 1'b0;
    // Reset values; count registers are checked after writes instead.
    rd_reg(ADDR_CTL_A, v); check("ctl a", CTL_RESET, v);
    rd_reg(ADDR_CTL_B, v); check("ctl b", CTL_RESET, v);
    rd_reg(ADDR_VECTOR, v); check("vector", VEC_NONE, v);
    // Reserved bits stay zero; flag plus enable raises a request.
    wr_reg(ADDR_CTL_A, 16'hFFFF);
    rd_reg(ADDR_CTL_A, v); check("ctl a mask", CTL_A_MASK, v);
    check("irq", 16'h0001, {15'h0, irq});
    wr_reg(ADDR_CTL_B, 16'hFFFF);
    rd_reg(ADDR_CTL_B, v); check("ctl b mask", CTL_B_MASK, v);
    wr_reg(ADDR_CTL_A, CTL_RESET);
    wr_reg(ADDR_CTL_B, CTL_RESET);
    // An unmapped index ignores writes and reads zero.
    wr_reg(4'hF, 16'hA5A5);
    rd_reg(4'hF, v); check("unmapped", 16'h0000, v);
    // Counters are plain read-write while held.
    for (int i = 0; i < 4; i++) begin
      r = 16'($urandom);
      wr_reg((i < 2) ? ADDR_CNT_A : ADDR_CNT_B, r);
      rd_reg((i < 2) ? ADDR_CNT_A : ADDR_CNT_B, v);
      check("count", {8'h00, r[7:0]}, v);
    end
    // Converters, read straight after the write, with corner values.
    for (int i = 0; i < 8; i++) begin
      r = (i == 0) ? 16'h0FFF : (i == 1) ? 16'h0000 : 16'($urandom);
      wr_reg(ADDR_TO_DEC, {4'h0, r[11:0]});
      rd_reg(ADDR_TO_DEC, v); check("to dec", to_dec(r[11:0]), v);
      r = (i == 0) ? 16'h4095 : {4'($urandom_range(0, 3)),
          4'($urandom_range(0, 9)), 4'($urandom_range(0, 9)),
          4'($urandom_range(0, 9))};
      wr_reg(ADDR_TO_BIN, r);
      rd_reg(ADDR_TO_BIN, v); check("to bin", to_bin(r), v);
    end
    // Backups survive the main reset and clear on the supply reset.
    r = 16'($urandom) | 16'h00FF;
    wr_reg(ADDR_SEC_BK, r);
    wr_reg(ADDR_MIN_BK, r);
    rd_reg(ADDR_SEC_BK, v); check("sec", {8'h0, r[7:0] & SEC_MASK}, v);
    rd_reg(ADDR_MIN_BK, v); check("min", {8'h0, r[7:0] & MIN_MASK}, v);
    @(posedge mclk);
    rst <= 1'b1;
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    rd_reg(ADDR_SEC_BK, v); check("sec kept", {8'h0, r[7:0] & SEC_MASK}, v);
    rd_reg(ADDR_CTL_B, v); check("ctl b rst", CTL_RESET, v);
    @(posedge mclk);
    supply_rst <= 1'b1;
    repeat (2) @(posedge mclk);
    supply_rst <= 1'b0;
    rd_reg(ADDR_MIN_BK, v); check("min clr", 16'h0000, v);
    // Every vector source in priority order; tamper is absent.
    wr_reg(ADDR_CTL_A, 16'h0103);
    wr_reg(ADDR_CTL_B, 16'h0103);
    @(posedge mclk);
    ext_set <= 5'b11101;
    @(posedge mclk);
    ext_set <= 5'b00000;
    for (int k = 0; k < 7; k++) begin
      repeat (2) @(posedge mclk);
      rd_reg(ADDR_VECTOR, v);
      check("vector", (k < 6) ? 16'(2 * k + 2) : VEC_NONE, v);
    end
    repeat (2) @(posedge mclk);
    check("irq off", 16'h0000, {14'h0, irq, wake});
    // Deep sleep loses the bits, the lock keeps the running setup.
    wr_reg(ADDR_CTL_A, 16'h0000);
    @(posedge mclk);
    lock <= 1'b1;
    sleep <= 1'b1;
    repeat (2) @(posedge mclk);
    sleep <= 1'b0;
    rd_reg(ADDR_CTL_A, v); check("ctl lost", CTL_RESET, v);
    rd_reg(ADDR_CNT_A, v);
    xstep(3);
    rd_reg(ADDR_CNT_A, w); check("locked run", {8'h0, v[7:0] + 8'h03}, w);
    @(posedge mclk);
    lock <= 1'b0;
    repeat (2) @(posedge mclk);
    rd_reg(ADDR_CNT_A, v);
    xstep(3);
    rd_reg(ADDR_CNT_A, w); check("held", v, w);
    // Every interval tap of both stages; stage b counts crystal rises.
    for (int k = 0; k < 8; k++) begin
      flag_period(ADDR_CTL_A, 16'(k << IP_LSB), n);
      check("interval a", 16'(2 << k), 16'(n));
      flag_period(ADDR_CTL_B, 16'(k << IP_LSB), n);
      check("interval b", 16'(2 << k), 16'(n));
    end
    // Every divide code through stage b, then the crystal sources.
    for (int i = 0; i < 10; i++) begin
      wr_reg(ADDR_CTL_A, 16'(((i < 8) ? i : 3) << DIV_LSB));
      wr_reg(ADDR_CTL_B, (i < 8) ? 16'h8000 : 16'((i - 8) << SRC_LSB));
      tick_period(n);
      check("tick", (i < 8) ? 16'(4 << i) : 16'h0002, 16'(n));
    end
    // Calendar mode ignores divide, source and hold fields.
    wr_reg(ADDR_CTL_A, CTL_RESET);
    @(posedge mclk);
    cal <= 1'b1;
    flag_period(ADDR_CTL_B, 16'h0102, n);
    check("calendar", 16'd512, 16'(n));
    check("wake", 16'h0003, {14'h0, irq, wake});
    @(posedge mclk);
    mhold <= 1'b1;
    rd_reg(ADDR_CNT_A, v);
    xstep(3);
    rd_reg(ADDR_CNT_A, w); check("module hold", v, w);
    print_verdict();
  end
endmodule // tb_rtc_prescale_vector_convert
`default_nettype wire
